//--- logic/ars_pkg.sv
package ars_pkg;
   // Sequence and channel geometry.
   localparam int SEQ_DEPTH = 16;
   localparam int CHAN_COUNT = 18;
   localparam int DISC_MAX = 8;
   localparam logic [4:0] TEMP_CHANNEL = 5'h10;
   localparam logic [4:0] VREF_CHANNEL = 5'h11;
   // Trigger source codes.
   localparam logic [2:0] TRIG_SW_CODE = 3'h7;
   localparam logic [2:0] TRIG_HW_LAST = 3'h6;
   // Conversion timing in half cycles: 12.5 cycles at 12-bit resolution.
   localparam int CONV_HALF_12 = 25;
   localparam int CONV_HALF_10 = 21;
   localparam int CONV_HALF_8 = 17;
   localparam int CONV_HALF_6 = 13;
   // Resolution codes.
   localparam logic [1:0] RES_12 = 2'h0;
   localparam logic [1:0] RES_10 = 2'h1;
   localparam logic [1:0] RES_8 = 2'h2;
   localparam logic [1:0] RES_6 = 2'h3;
   // Reset values.
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [11:0] UPPER_THRESHOLD_RESET = 12'hFFF;
   localparam logic [11:0] LOWER_THRESHOLD_RESET = 12'h000;

   // Sampling-time codes to half cycles: 1.5, 7.5, 13.5, 28.5, 41.5, 55.5, 71.5, 239.5.
   localparam logic [9:0] SAMPLE_HALF_0 = 10'h003;
   localparam logic [9:0] SAMPLE_HALF_1 = 10'h00F;
   localparam logic [9:0] SAMPLE_HALF_2 = 10'h01B;
   localparam logic [9:0] SAMPLE_HALF_3 = 10'h039;
   localparam logic [9:0] SAMPLE_HALF_4 = 10'h053;
   localparam logic [9:0] SAMPLE_HALF_5 = 10'h06F;
   localparam logic [9:0] SAMPLE_HALF_6 = 10'h08F;
   localparam logic [9:0] SAMPLE_HALF_7 = 10'h1DF;

   typedef struct packed {
      logic scan_select;
      logic continuous_select;
      logic discontinuous_select;
      logic [2:0] subsequence_count;
      logic [3:0] sequence_length;
      logic trigger_input_enable;
      logic [2:0] trigger_source_select;
      logic dma_enable;
      logic result_alignment;
      logic [1:0] resolution;
   } ars_mode_s;

   typedef struct packed {
      logic threshold_monitor_en;
      logic monitor_single_channel;
      logic [4:0] monitor_channel_number;
      logic [11:0] upper_threshold;
      logic [11:0] lower_threshold;
   } ars_monitor_s;

   typedef enum logic [1:0] {
      ARS_IDLE,
      ARS_SAMPLE,
      ARS_CONVERT,
      ARS_STORE
   } ars_state_e;
endpackage

//--- logic/ars_edge_detect.sv
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser followed by a rising-edge detector.
module ars_edge_detect (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Asynchronous level in, synchronous pulse out
   input wire logic async_in,
   output logic rise_pulse
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         last_q <= 1'b0;
      end else begin
         last_q <= sync_q;
      end
   end

   assign rise_pulse = sync_q & ~last_q;
endmodule
`default_nettype wire

//--- logic/ars_threshold_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Compares the raw, unaligned result against the window.
module ars_threshold_monitor (
   // Configuration
   input wire ars_pkg::ars_monitor_s monitor_cfg,
   // Result under test
   input wire logic result_valid,
   input wire logic [4:0] result_channel,
   input wire logic [11:0] raw_result,
   // Verdict
   output logic out_of_window
);
   logic watched;

   always_comb begin
      watched = 1'b0;
      if (monitor_cfg.threshold_monitor_en) begin
         watched = !monitor_cfg.monitor_single_channel ||
                   (result_channel == monitor_cfg.monitor_channel_number);
      end
   end

   assign out_of_window = result_valid && watched &&
                          ((raw_result > monitor_cfg.upper_threshold) ||
                           (raw_result < monitor_cfg.lower_threshold));
endmodule
`default_nettype wire

//--- logic/ars_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module ars_sequencer (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control
   input wire logic converter_on,
   input wire ars_pkg::ars_mode_s mode_cfg,
   input wire ars_pkg::ars_monitor_s monitor_cfg,
   input wire logic conversion_done_irq_en,
   input wire logic threshold_event_irq_en,
   input wire logic internal_channels_en,
   // Sequence list, five bits per entry, entry 0 in the low bits
   input wire logic [79:0] sequence_list,
   // Sampling-time codes, three bits per channel, channel 0 in the low bits
   input wire logic [53:0] channel_sample_cycles,
   // Software start and flag clears
   input wire logic sequence_soft_start_set,
   input wire logic conversion_done_clear,
   input wire logic threshold_event_clear,
   // Hardware trigger lines from outside the clock domain
   input wire logic [6:0] trigger_lines,
   // Converter core
   input wire logic [11:0] core_result,
   output logic core_sample,
   output logic [4:0] core_channel,
   output logic analog_power_en,
   output logic sensor_power_en,
   // Status and results
   output logic sequence_soft_start,
   output logic conversion_done_flag,
   output logic threshold_event_flag,
   output logic irq,
   output logic [15:0] result_data,
   output logic dma_request,
   output logic busy
);
   ars_pkg::ars_state_e state_q;
   logic [3:0] index_q;
   logic [2:0] burst_q;
   logic [9:0] half_q;
   logic [11:0] raw_q;
   logic [6:0] edge_pulse;
   logic hw_fire;
   logic sw_fire;
   logic start;
   logic last_entry;
   logic burst_end;
   logic out_of_window;
   logic store;
   logic [4:0] entry_channel;
   logic [3:0] next_index;
   logic [3:0] lookup_index;
   logic [4:0] lookup_channel;
   logic [2:0] sample_code;
   logic [9:0] sample_half;
   logic [9:0] conv_half;
   logic [15:0] aligned;

   // The whole sequencer is held in reset while the converter is off.
   logic run_n;
   assign run_n = rst_n & converter_on;
   assign analog_power_en = converter_on;
   assign sensor_power_en = converter_on & internal_channels_en;

   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_trig
         ars_edge_detect u_edge (
            .mclk(mclk),
            .rst_n(run_n),
            .async_in(trigger_lines[gi]),
            .rise_pulse(edge_pulse[gi])
         );
      end
   endgenerate

   // A source code of seven means only the software start bit counts.
   always_comb begin
      hw_fire = 1'b0;
      if (mode_cfg.trigger_input_enable && mode_cfg.trigger_source_select <= ars_pkg::TRIG_HW_LAST) begin
         hw_fire = edge_pulse[mode_cfg.trigger_source_select];
      end
   end
   assign sw_fire = sequence_soft_start &&
                    (!mode_cfg.trigger_input_enable ||
                     mode_cfg.trigger_source_select == ars_pkg::TRIG_SW_CODE);
   assign start = (state_q == ars_pkg::ARS_IDLE) && (hw_fire || sw_fire);

   assign entry_channel = sequence_list[index_q*5 +: 5];
   assign core_channel = entry_channel;
   // In the store cycle the lookup moves to the entry that follows, so each entry keeps its own sampling time.
   assign next_index = last_entry ? 4'h0 : index_q + 4'h1;
   assign lookup_index = store ? next_index : index_q;
   assign lookup_channel = sequence_list[lookup_index*5 +: 5];
   always_comb begin
      sample_code = 3'h0;
      if (lookup_channel < 5'(ars_pkg::CHAN_COUNT)) begin
         sample_code = channel_sample_cycles[lookup_channel*3 +: 3];
      end
   end

   always_comb begin
      case (sample_code)
         3'h0: sample_half = ars_pkg::SAMPLE_HALF_0;
         3'h1: sample_half = ars_pkg::SAMPLE_HALF_1;
         3'h2: sample_half = ars_pkg::SAMPLE_HALF_2;
         3'h3: sample_half = ars_pkg::SAMPLE_HALF_3;
         3'h4: sample_half = ars_pkg::SAMPLE_HALF_4;
         3'h5: sample_half = ars_pkg::SAMPLE_HALF_5;
         3'h6: sample_half = ars_pkg::SAMPLE_HALF_6;
         default: sample_half = ars_pkg::SAMPLE_HALF_7;
      endcase
   end

   always_comb begin
      case (mode_cfg.resolution)
         ars_pkg::RES_12: conv_half = 10'(ars_pkg::CONV_HALF_12);
         ars_pkg::RES_10: conv_half = 10'(ars_pkg::CONV_HALF_10);
         ars_pkg::RES_8: conv_half = 10'(ars_pkg::CONV_HALF_8);
         default: conv_half = 10'(ars_pkg::CONV_HALF_6);
      endcase
   end

   // Without scan or discontinuous mode only the first entry is converted.
   assign last_entry = !(mode_cfg.scan_select || mode_cfg.discontinuous_select) ||
                       (index_q == mode_cfg.sequence_length);
   assign burst_end = mode_cfg.discontinuous_select && (burst_q == mode_cfg.subsequence_count);
   assign store = (state_q == ars_pkg::ARS_STORE);

   // Timing runs in half cycles, two per clock; odd totals round up to a whole cycle.
   always_ff @(posedge mclk or negedge run_n) begin
      if (!run_n) begin
         state_q <= ars_pkg::ARS_IDLE;
         half_q <= 10'h000;
      end else begin
         case (state_q)
            ars_pkg::ARS_IDLE: begin
               if (start) begin
                  state_q <= ars_pkg::ARS_SAMPLE;
                  half_q <= sample_half;
               end
            end
            ars_pkg::ARS_SAMPLE: begin
               if (half_q <= 10'h002) begin
                  state_q <= ars_pkg::ARS_CONVERT;
                  half_q <= conv_half + (10'(half_q) - 10'h002);
               end else begin
                  half_q <= half_q - 10'h002;
               end
            end
            ars_pkg::ARS_CONVERT: begin
               if (half_q <= 10'h002) begin
                  state_q <= ars_pkg::ARS_STORE;
               end else begin
                  half_q <= half_q - 10'h002;
               end
            end
            ars_pkg::ARS_STORE: begin
               if (last_entry) begin
                  if (mode_cfg.continuous_select && !mode_cfg.discontinuous_select) begin
                     state_q <= ars_pkg::ARS_SAMPLE;
                     half_q <= sample_half;
                  end else begin
                     state_q <= ars_pkg::ARS_IDLE;
                  end
               end else if (burst_end) begin
                  state_q <= ars_pkg::ARS_IDLE;
               end else begin
                  state_q <= ars_pkg::ARS_SAMPLE;
                  half_q <= sample_half;
               end
            end
            default: state_q <= ars_pkg::ARS_IDLE;
         endcase
      end
   end

   // The index moves on at the same edge that loads the next entry's sampling time.
   always_ff @(posedge mclk or negedge run_n) begin
      if (!run_n) begin
         index_q <= 4'h0;
      end else if (store) begin
         index_q <= next_index;
      end
   end

   always_ff @(posedge mclk or negedge run_n) begin
      if (!run_n) begin
         burst_q <= 3'h0;
      end else if (start) begin
         burst_q <= 3'h0;
      end else if (store) begin
         burst_q <= burst_q + 3'h1;
      end
   end

   assign core_sample = (state_q == ars_pkg::ARS_SAMPLE);
   assign busy = (state_q != ars_pkg::ARS_IDLE);

   always_ff @(posedge mclk or negedge run_n) begin
      if (!run_n) begin
         sequence_soft_start <= 1'b0;
      end else if (sequence_soft_start_set && !sw_fire) begin
         sequence_soft_start <= 1'b1;
      end else if (start && sw_fire) begin
         sequence_soft_start <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge run_n) begin
      if (!run_n) begin
         raw_q <= 12'h000;
      end else if (state_q == ars_pkg::ARS_CONVERT && half_q <= 10'h002) begin
         raw_q <= core_result;
      end
   end

   // The low bits of a lower-resolution result are dropped before alignment.
   always_comb begin
      aligned = 16'h0000;
      case (mode_cfg.resolution)
         ars_pkg::RES_6: begin
            aligned = mode_cfg.result_alignment ? {8'h00, raw_q[11:6], 2'h0} : {10'h000, raw_q[11:6]};
         end
         ars_pkg::RES_8: begin
            aligned = mode_cfg.result_alignment ? {raw_q[11:4], 8'h00} : {8'h00, raw_q[11:4]};
         end
         ars_pkg::RES_10: begin
            aligned = mode_cfg.result_alignment ? {raw_q[11:2], 6'h00} : {6'h00, raw_q[11:2]};
         end
         default: begin
            aligned = mode_cfg.result_alignment ? {raw_q, 4'h0} : {4'h0, raw_q};
         end
      endcase
   end

   always_ff @(posedge mclk or negedge run_n) begin
      if (!run_n) begin
         result_data <= ars_pkg::RESULT_RESET;
      end else if (store) begin
         result_data <= aligned;
      end
   end

   always_ff @(posedge mclk or negedge run_n) begin
      if (!run_n) begin
         dma_request <= 1'b0;
      end else begin
         dma_request <= store && mode_cfg.dma_enable;
      end
   end

   ars_threshold_monitor u_monitor (
      .monitor_cfg(monitor_cfg),
      .result_valid(store),
      .result_channel(entry_channel),
      .raw_result(raw_q),
      .out_of_window(out_of_window)
   );

   // A hardware set in the same cycle as a clear wins.
   always_ff @(posedge mclk or negedge run_n) begin
      if (!run_n) begin
         conversion_done_flag <= 1'b0;
      end else if (store && last_entry) begin
         conversion_done_flag <= 1'b1;
      end else if (conversion_done_clear) begin
         conversion_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge run_n) begin
      if (!run_n) begin
         threshold_event_flag <= 1'b0;
      end else if (out_of_window) begin
         threshold_event_flag <= 1'b1;
      end else if (threshold_event_clear) begin
         threshold_event_flag <= 1'b0;
      end
   end

   assign irq = (conversion_done_flag && conversion_done_irq_en) ||
                (threshold_event_flag && threshold_event_irq_en);
endmodule
`default_nettype wire

//--- tb/ars_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module ars_core_model (
   // Converter core side
   input wire logic mclk,
   input wire logic core_sample,
   input wire logic [4:0] core_channel,
   output logic [11:0] core_result
);
   logic [4:0] held_q;
   logic [11:0] junk_q = 12'hA5A;
   // While sampling the output toggles, so a capture taken too early cannot look right.
   always @(posedge mclk) begin
      if (core_sample) held_q <= core_channel;
      junk_q <= ~junk_q;
   end
   assign core_result = core_sample ? junk_q : {held_q, 7'h2A};
endmodule
`default_nettype wire

//--- tb/ars_sequencer_props.sv
`timescale 1ns/100ps
`default_nettype none
module ars_sequencer_props (
   // Watched ports
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic converter_on,
   input wire ars_pkg::ars_mode_s mode_cfg,
   input wire logic conversion_done_irq_en,
   input wire logic threshold_event_irq_en,
   input wire logic internal_channels_en,
   input wire logic conversion_done_clear,
   input wire logic threshold_event_clear,
   input wire logic core_sample,
   input wire logic analog_power_en,
   input wire logic sensor_power_en,
   input wire logic sequence_soft_start,
   input wire logic conversion_done_flag,
   input wire logic threshold_event_flag,
   input wire logic irq,
   input wire logic [15:0] result_data,
   input wire logic dma_request,
   input wire logic busy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n || !converter_on);
   a_done_flag_holds: assert property (conversion_done_flag && !conversion_done_clear |=> conversion_done_flag)
      else $error("done flag dropped without a clear");
   a_done_flag_clears: assert property (conversion_done_flag && conversion_done_clear && !busy |=> !conversion_done_flag)
      else $error("done flag ignored its clear");
   a_event_flag_holds: assert property (threshold_event_flag && !threshold_event_clear |=> threshold_event_flag)
      else $error("event flag dropped without a clear");
   a_irq_from_flags: assert property (irq == ((conversion_done_flag && conversion_done_irq_en) ||
      (threshold_event_flag && threshold_event_irq_en)))
      else $error("irq does not match flags and enables");
   a_dma_single_pulse: assert property (dma_request |=> !dma_request)
      else $error("dma request longer than one cycle");
   a_done_with_dma: assert property ($rose(conversion_done_flag) && mode_cfg.dma_enable |-> dma_request)
      else $error("done flag rose without a final transfer");
   a_soft_start_taken: assert property (sequence_soft_start && !busy &&
      (!mode_cfg.trigger_input_enable || mode_cfg.trigger_source_select == ars_pkg::TRIG_SW_CODE)
      |-> ##[1:3] !sequence_soft_start)
      else $error("soft start bit did not clear");
   a_sample_first: assert property ($rose(busy) |-> core_sample)
      else $error("conversion did not begin by sampling");
   a_sensor_power: assert property (@(posedge mclk) disable iff (!rst_n)
      sensor_power_en == (converter_on && internal_channels_en))
      else $error("sensor power wrong");
   a_off_is_reset: assert property (@(posedge mclk) disable iff (!rst_n) !converter_on |->
      !busy && !dma_request && !conversion_done_flag && !analog_power_en && result_data == 16'h0000)
      else $error("block active while converter off");
   c_done_irq: cover property (conversion_done_flag && irq);
   c_event: cover property (threshold_event_flag && irq);
   c_cont: cover property (dma_request && mode_cfg.continuous_select);
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic converter_on = 1'b0;
   ars_pkg::ars_mode_s mode_cfg = '0;
   ars_pkg::ars_monitor_s monitor_cfg = '0;
   logic conversion_done_irq_en = 1'b0, threshold_event_irq_en = 1'b0, internal_channels_en = 1'b0;
   logic [79:0] sequence_list = '0;
   logic [53:0] channel_sample_cycles = '0;
   logic sequence_soft_start_set = 1'b0, conversion_done_clear = 1'b0, threshold_event_clear = 1'b0;
   logic [6:0] trigger_lines = 7'h00;
   logic [11:0] core_result;
   logic [4:0] core_channel;
   logic [15:0] result_data;
   logic core_sample, analog_power_en, sensor_power_en, sequence_soft_start, conversion_done_flag;
   logic threshold_event_flag, irq, dma_request, busy;
   int errors = 0, n_checks = 0, cyc = 0;
   ars_sequencer dut (.mclk, .rst_n, .converter_on, .mode_cfg, .monitor_cfg, .conversion_done_irq_en,
      .threshold_event_irq_en, .internal_channels_en, .sequence_list, .channel_sample_cycles,
      .sequence_soft_start_set, .conversion_done_clear, .threshold_event_clear, .trigger_lines, .core_result,
      .core_sample, .core_channel, .analog_power_en, .sensor_power_en, .sequence_soft_start,
      .conversion_done_flag, .threshold_event_flag, .irq, .result_data, .dma_request, .busy);
   ars_core_model core (.mclk, .core_sample, .core_channel, .core_result);
   initial forever #2.5 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   function automatic logic [15:0] ex(input logic [4:0] c);
      ex = {4'h0, c, 7'h2A};
   endfunction
   // Index 0 soft start, 1 done clear, 2 event clear.
   task automatic strobe(input int s);
      @(posedge mclk);
      {sequence_soft_start_set, conversion_done_clear, threshold_event_clear} <= 3'b100 >> s;
      @(posedge mclk);
      {sequence_soft_start_set, conversion_done_clear, threshold_event_clear} <= 3'b000;
   endtask
   task automatic get_word(output logic [15:0] w, output int t);
      int i;
      for (i = 0; i < 600; i++) begin
         @(posedge mclk);
         if (dma_request === 1'b1) break;
      end
      if (i == 600) errors++;
      w = result_data;
      t = cyc;
   endtask
   task automatic s_scan;
      ars_pkg::ars_mode_s m;
      logic [15:0] w;
      int t1, t2, t3;
      m = '0;
      m.scan_select = 1'b1;
      m.dma_enable = 1'b1;
      m.sequence_length = 4'h2;
      @(posedge mclk);
      mode_cfg <= m;
      sequence_list <= {65'h0, 5'h10, 5'h07, 5'h03};
      channel_sample_cycles <= 54'hE00000;
      conversion_done_irq_en <= 1'b1;
      strobe(0);
      get_word(w, t1);
      `CHK(w, ex(5'h03))
      `CHK(conversion_done_flag, 1'b0)
      get_word(w, t2);
      `CHK(w, ex(5'h07))
      get_word(w, t3);
      `CHK(w, ex(5'h10))
      `CHK(conversion_done_flag & irq, 1'b1)
      `CHK((t2 - t1) - (t3 - t2), 238)
      `CHK(t3 - t2, 15)
      `CHK(sequence_soft_start, 1'b0)
      repeat (40) @(posedge mclk);
      `CHK({busy, conversion_done_flag}, 2'b01)
      strobe(1);
      repeat (2) @(posedge mclk);
      `CHK(conversion_done_flag, 1'b0)
   endtask
   task automatic s_disc;
      ars_pkg::ars_mode_s m;
      logic [15:0] w;
      int t, k, j;
      m = '0;
      m.discontinuous_select = 1'b1;
      m.subsequence_count = 3'h1;
      m.sequence_length = 4'h3;
      m.dma_enable = 1'b1;
      m.trigger_input_enable = 1'b1;
      @(posedge mclk);
      sequence_list <= {60'h0, 5'h05, 5'h10, 5'h07, 5'h03};
      for (k = 0; k < 8; k++) begin
         m.trigger_source_select = k[2:0];
         mode_cfg <= m;
         @(posedge mclk);
         if (k == 7) strobe(0);
         else trigger_lines[k] <= 1'b1;
         for (j = 0; j < 2; j++) begin
            get_word(w, t);
            `CHK(w, ex(sequence_list[5 * ((2 * k + j) % 4) +: 5]))
         end
         `CHK(conversion_done_flag, k[0])
         repeat (30) @(posedge mclk);
         `CHK(busy, 1'b0)
         trigger_lines <= 7'h00;
         strobe(1);
      end
   endtask
   task automatic s_cont;
      ars_pkg::ars_mode_s m;
      logic [15:0] w;
      int t, j;
      m = '0;
      m.scan_select = 1'b1;
      m.continuous_select = 1'b1;
      m.dma_enable = 1'b1;
      m.sequence_length = 4'h1;
      @(posedge mclk);
      mode_cfg <= m;
      sequence_list <= {70'h0, 5'h10, 5'h03};
      strobe(0);
      for (j = 0; j < 5; j++) begin
         get_word(w, t);
         `CHK(w, ex(j[0] ? 5'h10 : 5'h03))
      end
      @(posedge mclk);
      converter_on <= 1'b0;
      mode_cfg <= '0;
      @(posedge mclk);
      `CHK({busy, conversion_done_flag, dma_request, analog_power_en, result_data}, 20'h00000)
      converter_on <= 1'b1;
   endtask
   task automatic s_align_mon;
      ars_pkg::ars_mode_s m;
      logic [15:0] w;
      logic [15:0] ev [8] = '{16'h082A, 16'h82A0, 16'h020A, 16'h8280, 16'h0082, 16'h8200, 16'h0020, 16'h0080};
      int t, k;
      m = '0;
      m.dma_enable = 1'b1;
      @(posedge mclk);
      sequence_list <= {75'h0, ars_pkg::TEMP_CHANNEL};
      internal_channels_en <= 1'b1;
      threshold_event_irq_en <= 1'b1;
      monitor_cfg <= '{1'b1, 1'b1, 5'h10, 12'h800, 12'h000};
      for (k = 0; k < 8; k++) begin
         m.resolution = k[2:1];
         m.result_alignment = k[0];
         mode_cfg <= m;
         strobe(0);
         get_word(w, t);
         `CHK(w, ev[k])
         `CHK(threshold_event_flag & irq & sensor_power_en, 1'b1)
         strobe(2);
      end
      monitor_cfg <= '{1'b1, 1'b1, 5'h03, 12'h800, 12'h000};
      strobe(0);
      get_word(w, t);
      `CHK(threshold_event_flag, 1'b0)
      internal_channels_en <= 1'b0;
      @(posedge mclk);
      `CHK(sensor_power_en, 1'b0)
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      converter_on <= 1'b1;
      s_scan;
      s_disc;
      s_cont;
      s_align_mon;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      report_and_stop;
   end
endmodule
bind ars_sequencer ars_sequencer_props u_props (.mclk, .rst_n, .converter_on, .mode_cfg, .conversion_done_irq_en,
   .threshold_event_irq_en, .internal_channels_en, .conversion_done_clear, .threshold_event_clear, .core_sample,
   .analog_power_en, .sensor_power_en, .sequence_soft_start, .conversion_done_flag, .threshold_event_flag, .irq,
   .result_data, .dma_request, .busy);
`default_nettype wire
